// ==== dv/pbo_pad_model.sv ====
`timescale 1ns/100ps
module pbo_pad_model
	import pbo_pkg::*;
(
	// Clock.
	input wire logic i_clk_sys,
	// Pad controls from the port.
	input wire logic [7:0] i_drive_enable_n,
	input wire logic [7:0] i_drive_value,
	input wire logic [7:0] i_pullup_enable,
	// Board-side drivers.
	input wire logic [7:0] i_ext_enable,
	input wire logic [7:0] i_ext_value,
	// Resolved pad levels.
	output logic [7:0] o_pad
);
	logic [7:0] float_q = 8'h55;

	// A pad nobody drives wanders, so it toggles each cycle.
	always @(posedge i_clk_sys) begin
		float_q <= ~float_q;
	end

	// Port drive wins, then the board, then the pull-up, else the floating level.
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!i_drive_enable_n[i]) begin
				o_pad[i] = i_drive_value[i];
			end else if (i_ext_enable[i]) begin
				o_pad[i] = i_ext_value[i];
			end else if (i_pullup_enable[i]) begin
				o_pad[i] = 1'b1;
			end else begin
				o_pad[i] = float_q[i];
			end
		end
	end
endmodule

// ==== dv/tb_pbo_port_override.sv ====
`timescale 1ns/100ps
`define CHK(nm, e, g) check(nm, (e), (g))
module tb_pbo_port_override
	import pbo_pkg::*;
;
	logic i_clk_sys = 1'b0;
	logic i_reset = 1'b1;
	logic [7:0] dir = 8'hff, outb = 8'hff, ext_en = 8'h00, ext_val = 8'h00;
	logic pu_off = 1'b0, slp = 1'b0, sp_en = 1'b0, sp_master = 1'b0, pss = 1'b0;
	logic sco = 1'b0, smo = 1'b0, smi = 1'b0;
	logic c0e = 1'b0, c0v = 1'b0, c1e = 1'b0, c1v = 1'b0;
	logic c2e1 = 1'b0, c2v1 = 1'b0, c2e0 = 1'b0, c2v0 = 1'b0;
	logic a4 = 1'b0, a7 = 1'b0, a6 = 1'b0, a5 = 1'b0, am = 1'b0, ie2 = 1'b0, ie1 = 1'b0;
	logic [7:0] pad, en_n, dval, pu, ie, pv;
	logic sck_in, mosi_in, miso_in, cap, irq2, irq1;
	logic [7:0] pats [2] = '{8'ha6, 8'h59};
	int errors = 0;
	int total_checks = 0;

	// Free-running system clock, 100 ns period.
	always #50 i_clk_sys = ~i_clk_sys;

	pbo_port_override pbo_port_override_i (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
		.i_direction(dir), .i_output_bits(outb), .i_global_pullup_disable(pu_off),
		.i_sleep(slp), .i_serial_port_enable(sp_en), .i_serial_master_select(sp_master),
		.i_serial_pin_set_select(pss), .i_serial_clock_out(sco), .i_serial_mosi_out(smo),
		.i_serial_miso_out(smi), .i_ctrl0_out1_enable(c0e), .i_ctrl0_out1_value(c0v),
		.i_ctrl1_out1_enable(c1e), .i_ctrl1_out1_value(c1v), .i_ctrl2_out1_enable(c2e1),
		.i_ctrl2_out1_value(c2v1), .i_ctrl2_out0_enable(c2e0), .i_ctrl2_out0_value(c2v0),
		.i_analog4_digital_disable(a4), .i_analog7_digital_disable(a7),
		.i_analog6_digital_disable(a6), .i_analog5_digital_disable(a5),
		.i_amp0_digital_disable(am), .i_ext_irq2_enable(ie2), .i_ext_irq1_enable(ie1),
		.i_pin(pad), .o_drive_enable_n(en_n), .o_drive_value(dval), .o_pullup_enable(pu),
		.o_input_enable(ie), .o_pin_value(pv), .o_serial_clock_input(sck_in),
		.o_serial_mosi_input(mosi_in), .o_serial_miso_input(miso_in),
		.o_timer1_alt_capture_input(cap), .o_ext_irq_source_2(irq2),
		.o_ext_irq_source_1(irq1));

	pbo_pad_model pbo_pad_model_i (.i_clk_sys(i_clk_sys), .i_drive_enable_n(en_n),
		.i_drive_value(dval), .i_pullup_enable(pu), .i_ext_enable(ext_en),
		.i_ext_value(ext_val), .o_pad(pad));

	// Compares one value and counts the outcome.
	task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask

	// Lets n rising edges pass and returns at a falling edge.
	task automatic tick(input int n);
		repeat (n) @(negedge i_clk_sys);
	endtask

	// Prints the counts and the verdict, then ends the run.
	task automatic test_done();
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// Cuts a hung run short.
	initial begin
		repeat (5000) @(posedge i_clk_sys);
		errors++;
		test_done();
	end

	// Main sequence.
	initial begin
		tick(5);
		`CHK("reset drive_enable_n", 8'hff, en_n);
		`CHK("reset pullup", 8'h00, pu | dval | ie | pv);
		i_reset = 1'b0;
		// Normal pull-up decode and the global disable.
		dir = 8'h0f;
		tick(1);
		`CHK("drive_enable_n", 8'hf0, en_n);
		`CHK("drive_value", 8'hff, dval);
		`CHK("pullup", 8'hf0, pu);
		`CHK("input_enable", 8'hff, ie);
		pu_off = 1'b1;
		tick(1);
		`CHK("pullup disabled", 8'h00, pu);
		// Serial slave mode; the data-out pin shows the serial level, not the output bit.
		pu_off = 1'b0;
		dir = 8'hff;
		sp_en = 1'b1;
		tick(1);
		`CHK("slave mosi dir", 8'h1, en_n[PIN_MOSI]);
		`CHK("slave mosi pullup", 8'h1, pu[PIN_MOSI]);
		`CHK("slave miso dir", 8'h0, en_n[PIN_MISO]);
		`CHK("slave miso value", 8'h0, dval[PIN_MISO]);
		`CHK("slave sck dir", 8'h1, en_n[PIN_SCK]);
		pu_off = 1'b1;
		tick(1);
		`CHK("slave mosi pullup off", 8'h0, pu[PIN_MOSI]);
		// Serial master mode.
		pu_off = 1'b0;
		sp_master = 1'b1;
		dir = 8'h00;
		tick(1);
		`CHK("master miso dir", 8'h1, en_n[PIN_MISO]);
		`CHK("master miso pullup", 8'h1, pu[PIN_MISO]);
		`CHK("master mosi dir low", 8'h1, en_n[PIN_MOSI]);
		dir = 8'hff;
		outb = 8'h00;
		sco = 1'b1;
		smo = 1'b1;
		tick(1);
		`CHK("master mosi dir high", 8'h0, en_n[PIN_MOSI]);
		`CHK("master miso dir forced", 8'h1, en_n[PIN_MISO]);
		`CHK("master mosi value", 8'h1, dval[PIN_MOSI]);
		`CHK("master sck value", 8'h1, dval[PIN_SCK]);
		// Controller outputs on released pins.
		sp_en = 1'b0;
		dir = 8'h00;
		{c0e, c0v, c1e, c1v, c2e1, c2v1, c2e0, c2v0} = 8'hfe;
		tick(1);
		`CHK("ctrl drive_enable_n", 8'h3c, en_n);
		`CHK("ctrl values", 8'hc2, dval & 8'hc3);
		{c0v, c1v, c2v1, c2v0} = 4'h1;
		tick(1);
		`CHK("ctrl values flipped", 8'h01, dval & 8'hc3);
		{c0e, c1e, c2e1, c2e0} = 4'h0;
		tick(1);
		`CHK("ctrl released", 8'hff, en_n);
		// Input enable overrides; analog pins lose the digital input, an enabled interrupt keeps it.
		slp = 1'b1;
		{ie2, ie1} = 2'b11;
		tick(1);
		`CHK("sleep irq input_enable", 8'h24, ie);
		slp = 1'b0;
		{ie2, ie1, a4, a7, a6, a5, am} = 7'h1f;
		tick(1);
		`CHK("analog input_enable", 8'h03, ie);
		ie2 = 1'b1;
		tick(1);
		`CHK("irq keeps input", 8'h23, ie);
		// Pad levels to peripherals, serial on this port then elsewhere.
		{ie2, a4, a7, a6, a5, am} = 6'h00;
		ext_en = 8'hff;
		sp_en = 1'b1;
		for (int k = 0; k < 2; k++) begin
			ext_val = pats[k];
			sp_master = 1'b0;
			pss = 1'b0;
			tick(6);
			`CHK("pin_value", pats[k], pv);
			`CHK("capture", pats[k][PIN_CAPTURE], cap);
			`CHK("irq2", pats[k][PIN_IRQ2], irq2);
			`CHK("irq1", pats[k][PIN_IRQ1], irq1);
			`CHK("sck in", pats[k][PIN_SCK], sck_in);
			`CHK("mosi in", pats[k][PIN_MOSI], mosi_in);
			sp_master = 1'b1;
			tick(2);
			`CHK("miso in", pats[k][PIN_MISO], miso_in);
			pss = 1'b1;
			tick(2);
			`CHK("serial ins off", 8'h0, {sck_in, mosi_in, miso_in});
		end
		// Reset again in mid-run.
		i_reset = 1'b1;
		tick(1);
		`CHK("mid reset drive_enable_n", 8'hff, en_n);
		test_done();
	end
endmodule

// ==== verilog/pbo_pin_sync.sv ====
`timescale 1ns/100ps
module pbo_pin_sync
	import pbo_pkg::*;
#(
	parameter int WIDTH = PORT_WIDTH
)(
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// Raw pin levels.
	input wire logic [WIDTH-1:0] i_pin,
	// Filtered pin levels.
	output logic [WIDTH-1:0] o_stable
);

	genvar g;

	// Each pin passes three stage flip-flops and then a holding flip-flop; a change is taken once the last two stages agree.
	generate
		for (g = 0; g < WIDTH; g++) begin : g_bit
			logic [SYNC_STAGES-1:0] stage;
			logic [SYNC_STAGES-1:0] next_stage;
			logic stable;
			logic next_stable;

			// Shift the pin in and accept a level the last two stages agree on.
			always_comb begin
				next_stage = {stage[SYNC_STAGES-2:0], i_pin[g]};
				next_stable = stable;
				if (stage[1] == stage[2]) begin
					next_stable = stage[2];
				end
			end

			// Register the chain and the accepted level.
			always_ff @(posedge i_clk_sys) begin
				if (i_reset) begin
					stage <= '0;
					stable <= 1'b0;
				end else begin
					stage <= next_stage;
					stable <= next_stable;
				end
			end

			assign o_stable[g] = stable;
		end
	endgenerate

endmodule

// ==== verilog/pbo_pkg.sv ====
package pbo_pkg;

	// Port width and the depth of the pin input synchroniser.
	localparam int PORT_WIDTH = 8;
	localparam int SYNC_STAGES = 3;

	// Pin positions of the alternate functions on this port.
	localparam int PIN_SCK = 7;
	localparam int PIN_CAPTURE = 6;
	localparam int PIN_IRQ2 = 5;
	localparam int PIN_AMP_POS = 4;
	localparam int PIN_AMP_NEG = 3;
	localparam int PIN_IRQ1 = 2;
	localparam int PIN_MOSI = 1;
	localparam int PIN_MISO = 0;

	// Reset values of the pin control outputs: all pins released, no pull-ups.
	localparam logic [7:0] RST_DRIVE_ENABLE_N = 8'hff;
	localparam logic [7:0] RST_DRIVE_VALUE = 8'h00;
	localparam logic [7:0] RST_PULLUP = 8'h00;
	localparam logic [7:0] RST_INPUT_ENABLE = 8'h00;
	localparam logic [7:0] RST_PIN_VALUE = 8'h00;

endpackage

// ==== verilog/pbo_port_override.sv ====
`timescale 1ns/100ps
// Function
// - Slave mode forces data-in pin to input.
// - Master mode: data-in pin direction from bit.
// - Forced input keeps pull-up from output bit.
// - Master mode forces data-out pin to input.
// - Slave mode: data-out pin direction from bit.
// - Bit 6 feeds timer 1 alternate capture.
// - Bit 5 feeds external interrupt 2.
// - Bit 2 feeds external interrupt 1.
// - Controller outputs drive bits 7, 6, 1, 0.
// - Bit 1 delivers qualified serial data input.
// - Bit 0 delivers qualified serial data input.
// - Bit 7 delivers qualified serial clock input.
// - Bit 7 driven by controller 0, serial overrides.
// - Pull-up from override or direction/output/disable 010.
// - Global disable turns off all normal pull-ups.
module pbo_port_override
	import pbo_pkg::*;
(
	// Clock and reset.
	input wire logic i_clk_sys,
	input wire logic i_reset,
	// Port control bits.
	input wire logic [7:0] i_direction,
	input wire logic [7:0] i_output_bits,
	input wire logic i_global_pullup_disable,
	input wire logic i_sleep,
	// Serial port control and outgoing levels.
	input wire logic i_serial_port_enable,
	input wire logic i_serial_master_select,
	input wire logic i_serial_pin_set_select,
	input wire logic i_serial_clock_out,
	input wire logic i_serial_mosi_out,
	input wire logic i_serial_miso_out,
	// Power stage controller outputs.
	input wire logic i_ctrl0_out1_enable,
	input wire logic i_ctrl0_out1_value,
	input wire logic i_ctrl1_out1_enable,
	input wire logic i_ctrl1_out1_value,
	input wire logic i_ctrl2_out1_enable,
	input wire logic i_ctrl2_out1_value,
	input wire logic i_ctrl2_out0_enable,
	input wire logic i_ctrl2_out0_value,
	// Analog digital-disable and interrupt enables.
	input wire logic i_analog4_digital_disable,
	input wire logic i_analog7_digital_disable,
	input wire logic i_analog6_digital_disable,
	input wire logic i_analog5_digital_disable,
	input wire logic i_amp0_digital_disable,
	input wire logic i_ext_irq2_enable,
	input wire logic i_ext_irq1_enable,
	// Pad levels.
	input wire logic [7:0] i_pin,
	// Pad controls.
	output logic [7:0] o_drive_enable_n,
	output logic [7:0] o_drive_value,
	output logic [7:0] o_pullup_enable,
	output logic [7:0] o_input_enable,
	output logic [7:0] o_pin_value,
	// Inputs delivered to peripherals.
	output logic o_serial_clock_input,
	output logic o_serial_mosi_input,
	output logic o_serial_miso_input,
	output logic o_timer1_alt_capture_input,
	output logic o_ext_irq_source_2,
	output logic o_ext_irq_source_1
);

	logic [7:0] pin_stable;
	logic spi_on_port;
	logic spi_master;
	logic spi_slave;
	logic forced_pullup_1;
	logic forced_pullup_0;
	logic forced_pullup_7;
	logic [7:0] pullup_ov_en;
	logic [7:0] pullup_ov_val;
	logic [7:0] dir_ov_en;
	logic [7:0] dir_ov_val;
	logic [7:0] val_ov_en;
	logic [7:0] val_ov_val;
	logic [7:0] ie_ov_en;
	logic [7:0] ie_ov_val;
	logic [7:0] next_drive_enable_n;
	logic [7:0] next_drive_value;
	logic [7:0] next_pullup_enable;
	logic [7:0] next_input_enable;
	logic [7:0] next_pin_value;
	logic next_serial_clock_input;
	logic next_serial_mosi_input;
	logic next_serial_miso_input;
	logic next_capture;
	logic next_irq2;
	logic next_irq1;

	// Pad inputs come from outside the clock domain.
	pbo_pin_sync #(
		.WIDTH(PORT_WIDTH)
	) u_sync (
		.i_clk_sys(i_clk_sys),
		.i_reset(i_reset),
		.i_pin(i_pin),
		.o_stable(pin_stable)
	);

	// The serial port owns these pins only while the alternate pin set is not chosen.
	assign spi_on_port = i_serial_port_enable & ~i_serial_pin_set_select;
	assign spi_master = spi_on_port & i_serial_master_select;
	assign spi_slave = spi_on_port & ~i_serial_master_select;
	assign forced_pullup_7 = i_output_bits[PIN_SCK] & ~i_global_pullup_disable;
	assign forced_pullup_1 = i_output_bits[PIN_MOSI] & ~i_global_pullup_disable;
	assign forced_pullup_0 = i_output_bits[PIN_MISO] & ~i_global_pullup_disable;

	// Override terms of every pin; a pin without a function keeps normal control.
	always_comb begin
		pullup_ov_en = 8'h00;
		pullup_ov_val = 8'h00;
		dir_ov_en = 8'h00;
		dir_ov_val = 8'h00;
		val_ov_en = 8'h00;
		val_ov_val = 8'h00;
		ie_ov_en = 8'h00;
		ie_ov_val = 8'h00;
		// Clock pin: serial port first, then controller 0 output 1.
		if (spi_slave) begin
			dir_ov_en[PIN_SCK] = 1'b1;
			pullup_ov_en[PIN_SCK] = 1'b1;
			pullup_ov_val[PIN_SCK] = forced_pullup_7;
		end else if (spi_master) begin
			val_ov_en[PIN_SCK] = 1'b1;
			val_ov_val[PIN_SCK] = i_serial_clock_out;
		end else if (i_ctrl0_out1_enable) begin
			dir_ov_en[PIN_SCK] = 1'b1;
			dir_ov_val[PIN_SCK] = 1'b1;
			val_ov_en[PIN_SCK] = 1'b1;
			val_ov_val[PIN_SCK] = i_ctrl0_out1_value;
		end
		// Capture pin driven by controller 1 output 1.
		if (i_ctrl1_out1_enable) begin
			dir_ov_en[PIN_CAPTURE] = 1'b1;
			dir_ov_val[PIN_CAPTURE] = 1'b1;
			val_ov_en[PIN_CAPTURE] = 1'b1;
			val_ov_val[PIN_CAPTURE] = i_ctrl1_out1_value;
		end
		// Data-in pin: slave forces input, master drives, else controller 2.
		if (spi_slave) begin
			dir_ov_en[PIN_MOSI] = 1'b1;
			pullup_ov_en[PIN_MOSI] = 1'b1;
			pullup_ov_val[PIN_MOSI] = forced_pullup_1;
		end else if (spi_master) begin
			val_ov_en[PIN_MOSI] = 1'b1;
			val_ov_val[PIN_MOSI] = i_serial_mosi_out;
		end else if (i_ctrl2_out1_enable) begin
			dir_ov_en[PIN_MOSI] = 1'b1;
			dir_ov_val[PIN_MOSI] = 1'b1;
			val_ov_en[PIN_MOSI] = 1'b1;
			val_ov_val[PIN_MOSI] = i_ctrl2_out1_value;
		end
		// Data-out pin: master forces input, slave drives, else controller 2.
		if (spi_master) begin
			dir_ov_en[PIN_MISO] = 1'b1;
			pullup_ov_en[PIN_MISO] = 1'b1;
			pullup_ov_val[PIN_MISO] = forced_pullup_0;
		end else if (spi_slave) begin
			val_ov_en[PIN_MISO] = 1'b1;
			val_ov_val[PIN_MISO] = i_serial_miso_out;
		end else if (i_ctrl2_out0_enable) begin
			dir_ov_en[PIN_MISO] = 1'b1;
			dir_ov_val[PIN_MISO] = 1'b1;
			val_ov_en[PIN_MISO] = 1'b1;
			val_ov_val[PIN_MISO] = i_ctrl2_out0_value;
		end
		// Analog pins turn the digital input off; an enabled interrupt keeps it on.
		ie_ov_en[PIN_SCK] = i_analog4_digital_disable;
		ie_ov_en[PIN_CAPTURE] = i_analog7_digital_disable;
		ie_ov_en[PIN_IRQ2] = i_analog6_digital_disable | i_ext_irq2_enable;
		ie_ov_val[PIN_IRQ2] = i_ext_irq2_enable;
		ie_ov_en[PIN_AMP_POS] = i_amp0_digital_disable;
		ie_ov_en[PIN_AMP_NEG] = i_amp0_digital_disable;
		ie_ov_en[PIN_IRQ1] = i_analog5_digital_disable | i_ext_irq1_enable;
		ie_ov_val[PIN_IRQ1] = i_ext_irq1_enable;
	end

	// Resolve each pin's controls and the inputs handed to peripherals.
	always_comb begin
		for (int i = 0; i < PORT_WIDTH; i++) begin
			next_drive_enable_n[i] = dir_ov_en[i] ? ~dir_ov_val[i] : ~i_direction[i];
			next_drive_value[i] = val_ov_en[i] ? val_ov_val[i] : i_output_bits[i];
			next_pullup_enable[i] = pullup_ov_en[i] ? pullup_ov_val[i] :
				(~i_direction[i] & i_output_bits[i] & ~i_global_pullup_disable);
			next_input_enable[i] = ie_ov_en[i] ? ie_ov_val[i] : ~i_sleep;
		end
		next_pin_value = pin_stable & next_input_enable;
		next_serial_clock_input = next_pin_value[PIN_SCK] & spi_on_port & ~i_reset;
		next_serial_mosi_input = next_pin_value[PIN_MOSI] & spi_on_port & ~i_reset;
		next_serial_miso_input = next_pin_value[PIN_MISO] & spi_on_port & ~i_reset;
		next_capture = next_pin_value[PIN_CAPTURE];
		next_irq2 = next_pin_value[PIN_IRQ2];
		next_irq1 = next_pin_value[PIN_IRQ1];
	end

	// Register every output; reset releases all pins.
	always_ff @(posedge i_clk_sys) begin
		if (i_reset) begin
			o_drive_enable_n <= RST_DRIVE_ENABLE_N;
			o_drive_value <= RST_DRIVE_VALUE;
			o_pullup_enable <= RST_PULLUP;
			o_input_enable <= RST_INPUT_ENABLE;
			o_pin_value <= RST_PIN_VALUE;
			o_serial_clock_input <= 1'b0;
			o_serial_mosi_input <= 1'b0;
			o_serial_miso_input <= 1'b0;
			o_timer1_alt_capture_input <= 1'b0;
			o_ext_irq_source_2 <= 1'b0;
			o_ext_irq_source_1 <= 1'b0;
		end else begin
			o_drive_enable_n <= next_drive_enable_n;
			o_drive_value <= next_drive_value;
			o_pullup_enable <= next_pullup_enable;
			o_input_enable <= next_input_enable;
			o_pin_value <= next_pin_value;
			o_serial_clock_input <= next_serial_clock_input;
			o_serial_mosi_input <= next_serial_mosi_input;
			o_serial_miso_input <= next_serial_miso_input;
			o_timer1_alt_capture_input <= next_capture;
			o_ext_irq_source_2 <= next_irq2;
			o_ext_irq_source_1 <= next_irq1;
		end
	end

	// Checks on the registered pin controls.
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	property p_mosi_slave_input;
		spi_slave |=> o_drive_enable_n[PIN_MOSI];
	endproperty
	a_mosi_slave_input: assert property (p_mosi_slave_input)
		else $error("Data-in pin not forced to input in slave mode.");

	property p_mosi_master_dir;
		spi_master |=> o_drive_enable_n[PIN_MOSI] == !$past(i_direction[PIN_MOSI]);
	endproperty
	a_mosi_master_dir: assert property (p_mosi_master_dir)
		else $error("Data-in pin direction wrong in master mode.");

	property p_forced_pullup;
		spi_slave |=> o_pullup_enable[PIN_MOSI] ==
			$past(i_output_bits[PIN_MOSI] & !i_global_pullup_disable);
	endproperty
	a_forced_pullup: assert property (p_forced_pullup)
		else $error("Forced input pin lost its pull-up control.");

	property p_miso_master_input;
		spi_master |=> o_drive_enable_n[PIN_MISO];
	endproperty
	a_miso_master_input: assert property (p_miso_master_input)
		else $error("Data-out pin not forced to input in master mode.");

	property p_miso_slave_dir;
		spi_slave |=> o_drive_enable_n[PIN_MISO] == !$past(i_direction[PIN_MISO]);
	endproperty
	a_miso_slave_dir: assert property (p_miso_slave_dir)
		else $error("Data-out pin direction wrong in slave mode.");

	// Peripheral inputs follow the synchronised pad, gated by the input enable.
	property p_capture_route;
		o_timer1_alt_capture_input ==
			($past(pin_stable[PIN_CAPTURE]) && o_input_enable[PIN_CAPTURE]);
	endproperty
	a_capture_route: assert property (p_capture_route)
		else $error("Capture input does not follow bit 6.");

	property p_irq_route;
		o_ext_irq_source_2 == ($past(pin_stable[PIN_IRQ2]) && o_input_enable[PIN_IRQ2]);
	endproperty
	a_irq_route: assert property (p_irq_route)
		else $error("Interrupt 2 input does not follow bit 5.");

	property p_irq1_route;
		o_ext_irq_source_1 == ($past(pin_stable[PIN_IRQ1]) && o_input_enable[PIN_IRQ1]);
	endproperty
	a_irq1_route: assert property (p_irq1_route)
		else $error("Interrupt 1 input does not follow bit 2.");

	property p_serial_in_qualified;
		(o_serial_clock_input || o_serial_mosi_input || o_serial_miso_input) |->
			$past(spi_on_port);
	endproperty
	a_serial_in_qualified: assert property (p_serial_in_qualified)
		else $error("Serial input delivered while the port is not selected.");

	property p_ctrl1_drive;
		i_ctrl1_out1_enable |=> !o_drive_enable_n[PIN_CAPTURE] &&
			o_drive_value[PIN_CAPTURE] == $past(i_ctrl1_out1_value);
	endproperty
	a_ctrl1_drive: assert property (p_ctrl1_drive)
		else $error("Controller 1 output not driven on bit 6.");

	property p_ctrl0_drive;
		(i_ctrl0_out1_enable && !spi_on_port) |=> !o_drive_enable_n[PIN_SCK] &&
			o_drive_value[PIN_SCK] == $past(i_ctrl0_out1_value);
	endproperty
	a_ctrl0_drive: assert property (p_ctrl0_drive)
		else $error("Controller 0 output not driven on bit 7.");

	property p_base_pullup;
		(!i_direction[PIN_AMP_POS] && i_output_bits[PIN_AMP_POS]) |=>
			o_pullup_enable[PIN_AMP_POS] == !$past(i_global_pullup_disable);
	endproperty
	a_base_pullup: assert property (p_base_pullup)
		else $error("Normal pull-up setting not applied.");

	property p_global_disable;
		i_global_pullup_disable |=> o_pullup_enable[PIN_AMP_NEG:PIN_IRQ1] == 2'b00;
	endproperty
	a_global_disable: assert property (p_global_disable)
		else $error("Pull-up on while globally disabled.");

	property p_irq_keeps_input;
		i_ext_irq2_enable |=> o_input_enable[PIN_IRQ2];
	endproperty
	a_irq_keeps_input: assert property (p_irq_keeps_input)
		else $error("Interrupt pin input disabled while interrupt enabled.");

	c_master: cover property (spi_master ##1 o_serial_miso_input);
	c_slave: cover property (spi_slave ##1 o_serial_clock_input);
	c_ctrl2: cover property (i_ctrl2_out0_enable && !spi_on_port ##1 !o_drive_enable_n[PIN_MISO]);

endmodule
